// >>> hdl/flash_bus_cycle.v
// One read or write cycle on the flash parallel bus
`timescale 1ns/100ps
module flash_bus_cycle #(
	parameter ADDR_W = 20,
	parameter DATA_W = 8,
	parameter HOLD   = 3
) (
	// Clock and reset
	input  wire              ref_clk,
	input  wire              sys_rst,
	// Request
	input  wire              start,
	input  wire              is_write,
	input  wire [ADDR_W-1:0] addr,
	input  wire [DATA_W-1:0] wdata,
	output wire              idle,
	output reg               done,
	output reg  [DATA_W-1:0] rdata,
	// Flash pins
	output reg  [ADDR_W-1:0] flash_addr,
	input  wire [DATA_W-1:0] flash_dq_in,
	output reg  [DATA_W-1:0] flash_dq_out,
	output reg               flash_dq_oe,
	output reg               flash_ce_n,
	output reg               flash_oe_n,
	output reg               flash_we_n
);

	reg [3:0] cnt;
	reg       busy;

	assign idle = ~busy;

	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt          <= 4'h0;
			busy         <= 1'b0;
			done         <= 1'b0;
			rdata        <= {DATA_W{1'b0}};
			flash_addr   <= {ADDR_W{1'b0}};
			flash_dq_out <= {DATA_W{1'b0}};
			flash_dq_oe  <= 1'b0;
			flash_ce_n   <= 1'b1;
			flash_oe_n   <= 1'b1;
			flash_we_n   <= 1'b1;
		end else begin
			done <= 1'b0;
			if (!busy) begin
				if (start) begin
					busy         <= 1'b1;
					cnt          <= HOLD[3:0];
					flash_addr   <= addr;
					flash_dq_out <= wdata;
					flash_dq_oe  <= is_write;
					flash_ce_n   <= 1'b0;
					flash_oe_n   <= is_write;
					flash_we_n   <= ~is_write;
				end
			end else if (cnt != 4'h0) begin
				cnt <= cnt - 4'h1;
			end else begin
				// Sample just before strobes rise; write data latches on we rising
				busy        <= 1'b0;
				done        <= 1'b1;
				rdata       <= flash_dq_in;
				flash_ce_n  <= 1'b1;
				flash_oe_n  <= 1'b1;
				flash_we_n  <= 1'b1;
				flash_dq_oe <= 1'b0;
			end
		end
	end

endmodule // flash_bus_cycle

// >>> hdl/flash_status_poller.v
// Host-side poller that watches flash program and erase status
`timescale 1ns/100ps
`include "flash_status_map.vh"

module flash_status_poller #(
	parameter ADDR_W = 20,
	parameter DATA_W = 8
) (
	// Clock and reset
	input  wire              ref_clk,
	input  wire              sys_rst,
	// User orders
	input  wire              poll_start,
	input  wire [1:0]        poll_mode,
	input  wire [ADDR_W-1:0] poll_addr,
	input  wire [7:0]        poll_data,
	input  wire              window_check,
	output wire              poll_ready,
	output reg               poll_done,
	output reg               poll_ok,
	output reg               poll_fail,
	output reg               window_open,
	output reg               window_valid,
	output reg               suspended,
	output reg  [7:0]        last_status,
	// Flash pins
	output wire [ADDR_W-1:0] flash_addr,
	input  wire [DATA_W-1:0] flash_dq_in,
	output wire [DATA_W-1:0] flash_dq_out,
	output wire              flash_dq_oe,
	output wire              flash_ce_n,
	output wire              flash_oe_n,
	output wire              flash_we_n,
	input  wire              ready_busy_n_in,
	output wire              ready_busy_n_out,
	output wire              ready_busy_n_oe
);

	// Poll modes
	localparam MODE_TOGGLE  = 2'h0;
	localparam MODE_DPOLL   = 2'h1;
	localparam MODE_ERASE   = 2'h2;

	localparam S_IDLE   = 3'h0;
	localparam S_READ1  = 3'h1;
	localparam S_READ2  = 3'h2;
	localparam S_CHECK  = 3'h3;
	localparam S_RECHK  = 3'h4;
	localparam S_RESET  = 3'h5;
	localparam S_WIN    = 3'h6;

	// Reset command widened to the bus; avoids a zero-width pad when the bus is a byte
	localparam [DATA_W-1:0] RESET_WORD = `RESET_CMD;

	reg  [2:0]        state;
	reg  [1:0]        mode;
	reg  [ADDR_W-1:0] addr;
	reg  [7:0]        exp_data;
	reg  [7:0]        first;
	reg               fail_seen;
	reg               cyc_start;
	reg               cyc_write;
	wire              cyc_idle;
	wire              cyc_done;
	wire [DATA_W-1:0] cyc_rdata;
	wire [7:0]        rd;

	// Host only listens on the ready/busy line; never drives it
	assign ready_busy_n_out = 1'b0;
	assign ready_busy_n_oe  = 1'b0;
	assign poll_ready       = (state == S_IDLE) && cyc_idle && !cyc_start;
	assign rd               = cyc_rdata[7:0];

	function toggled;
		input [7:0] a;
		input [7:0] b;
		begin
			toggled = (a[`TOGGLE_ANY_BIT] != b[`TOGGLE_ANY_BIT]);
		end
	endfunction

	function [ADDR_W-1:0] rd_addr;
		input [ADDR_W-1:0] a;
		begin
			rd_addr = a;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Status sequencer

	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state        <= S_IDLE;
			mode         <= MODE_TOGGLE;
			addr         <= {ADDR_W{1'b0}};
			exp_data     <= 8'h00;
			first        <= 8'h00;
			fail_seen    <= 1'b0;
			cyc_start    <= 1'b0;
			cyc_write    <= 1'b0;
			poll_done    <= 1'b0;
			poll_ok      <= 1'b0;
			poll_fail    <= 1'b0;
			window_open  <= 1'b0;
			window_valid <= 1'b0;
			suspended    <= 1'b0;
			last_status  <= 8'h00;
		end else begin
			cyc_start <= 1'b0;
			poll_done <= 1'b0;
			case (state)
				S_IDLE: begin
					if (poll_start && poll_ready) begin
						mode      <= poll_mode;
						addr      <= poll_addr;
						exp_data  <= poll_data;
						fail_seen <= 1'b0;
						cyc_write <= 1'b0;
						cyc_start <= 1'b1;
						// Sector erase always reads the window bit, so spacing is never assumed
						state     <= (poll_mode == MODE_ERASE || window_check) ? S_WIN : S_READ1;
					end
				end
				S_WIN: begin
					// Sector erase or window_check; window_valid only for sector erase, chip erase has no window
					if (cyc_done) begin
						last_status  <= rd;
						window_open  <= ~rd[`ERASE_WINDOW_BIT];
						window_valid <= (mode == MODE_ERASE);
						cyc_start    <= 1'b1;
						state        <= S_READ1;
					end
				end
				S_READ1: begin
					if (cyc_done) begin
						first     <= rd;
						cyc_start <= 1'b1;
						state     <= S_READ2;
					end
				end
				S_READ2: begin
					if (cyc_done) begin
						last_status <= rd;
						state       <= S_CHECK;
					end
				end
				S_CHECK: begin
					if (mode == MODE_DPOLL && last_status[`DATA_POLL_BIT] == exp_data[7]) begin
						poll_ok   <= 1'b1;
						poll_fail <= 1'b0;
						poll_done <= 1'b1;
						suspended <= 1'b0;
						state     <= S_IDLE;
					end else if (!toggled(first, last_status) &&
					             (mode != MODE_DPOLL || fail_seen)) begin
						// Stopped toggling: done, or suspended if sector bit still flips
						poll_ok   <= !fail_seen || !toggled(first, last_status);
						poll_fail <= 1'b0;
						suspended <= (mode == MODE_ERASE) &&
						             (first[`TOGGLE_SECTOR_BIT] != last_status[`TOGGLE_SECTOR_BIT]) &&
						             last_status[`DATA_POLL_BIT];
						poll_done <= 1'b1;
						state     <= S_IDLE;
					end else if (last_status[`TIMEOUT_FAIL_BIT] && !fail_seen) begin
						fail_seen <= 1'b1;
						first     <= last_status;
						cyc_start <= 1'b1;
						state     <= S_RECHK;
					end else if (fail_seen) begin
						cyc_write <= 1'b1;
						cyc_start <= 1'b1;
						state     <= S_RESET;
					end else if (ready_busy_n_in && mode != MODE_DPOLL &&
					             !toggled(first, last_status)) begin
						poll_ok   <= 1'b1;
						poll_fail <= 1'b0;
						suspended <= 1'b0;
						poll_done <= 1'b1;
						state     <= S_IDLE;
					end else begin
						// Keep polling; protected-sector cases stop by themselves
						first     <= last_status;
						cyc_start <= 1'b1;
						state     <= S_READ2;
					end
				end
				S_RECHK: begin
					if (cyc_done) begin
						last_status <= rd;
						state       <= S_CHECK;
					end
				end
				S_RESET: begin
					if (cyc_done) begin
						cyc_write <= 1'b0;
						poll_ok   <= 1'b0;
						poll_fail <= 1'b1;
						suspended <= 1'b0;
						poll_done <= 1'b1;
						state     <= S_IDLE;
					end
				end
				default: state <= S_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bus cycle engine

	flash_bus_cycle #(
		.ADDR_W (ADDR_W),
		.DATA_W (DATA_W),
		.HOLD   (`READ_CYCLE_CYC)
	) u_cycle (
		.ref_clk      (ref_clk),
		.sys_rst      (sys_rst),
		.start        (cyc_start),
		.is_write     (cyc_write),
		.addr         (rd_addr(addr)),
		.wdata        (RESET_WORD),
		.idle         (cyc_idle),
		.done         (cyc_done),
		.rdata        (cyc_rdata),
		.flash_addr   (flash_addr),
		.flash_dq_in  (flash_dq_in),
		.flash_dq_out (flash_dq_out),
		.flash_dq_oe  (flash_dq_oe),
		.flash_ce_n   (flash_ce_n),
		.flash_oe_n   (flash_oe_n),
		.flash_we_n   (flash_we_n)
	);

endmodule // flash_status_poller

// >>> pkg/flash_status_map.vh
// Constants for the flash status poller: bus bit positions, commands and timing counts
`ifndef FLASH_STATUS_MAP_VH
`define FLASH_STATUS_MAP_VH

// Status bit positions in the data byte
`define DATA_POLL_BIT      7
`define TOGGLE_ANY_BIT     6
`define TIMEOUT_FAIL_BIT   5
`define ERASE_WINDOW_BIT   3
`define TOGGLE_SECTOR_BIT  2

// Reset command, written to any address
`define RESET_CMD          8'hf0

// Timing in ns or us and derived cycle counts at 100 ns per cycle
`define CLK_PERIOD_NS      100
`define READ_CYCLE_NS      300
`define READ_CYCLE_CYC     ((`READ_CYCLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_PULSE_NS     200
`define WRITE_PULSE_CYC    ((`WRITE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WINDOW_SPACING_US  50
`define WINDOW_SPACING_CYC ((`WINDOW_SPACING_US * 1000) / `CLK_PERIOD_NS)

`endif

// >>> tb/flash_dev_model.sv
// Behavioural flash device answering status reads
`timescale 1ns/100ps
module flash_dev_model (
	// Host strobes
	input  wire       ce_n,
	input  wire       oe_n,
	input  wire       we_n,
	input  wire [7:0] din,
	// Device outputs
	output wire [7:0] dout,
	output wire       busy
);
	// Set by the bench: 0 array, 1 program, 2 erase, 3 suspend
	reg  [1:0] op    = 2'h0;
	reg  [7:0] left  = 8'h00;
	reg        fail  = 1'b0;
	reg        win   = 1'b0;
	reg  [7:0] pdata = 8'h00;
	reg        tog   = 1'b0;
	reg  [7:0] last  = 8'h00;
	wire       rd    = !ce_n && !oe_n;
	wire       wr    = !ce_n && !we_n;
	wire [7:0] stat;
	wire [7:0] cur;
	assign busy = op == 2'h1 || op == 2'h2;
	assign stat = {op == 2'h1 ? ~pdata[7] : op == 2'h3,
		busy & tog, fail, 1'b0, win, op[1] & tog, 2'h0};
	assign cur  = (op == 2'h0) ? pdata : stat;
	// Released bus shows the inverse so stale data never passes
	assign dout = rd ? cur : ~last;
	always @(negedge rd) begin
		last = cur;
		tog = ~tog;
		if (busy && left != 8'h00)
			left = left - 8'h01;
		else if (busy && !fail)
			op = 2'h0;
	end
	always @(negedge wr) begin
		if (din == 8'hf0) begin
			op = 2'h0;
			fail = 1'b0;
		end
	end
endmodule // flash_dev_model

// >>> tb/flash_status_poller_props.sv
// Checker for the bus discipline of the status poller
`timescale 1ns/100ps
module flash_status_poller_props #(
	parameter ADDR_W = 20
) (
	// Clock and reset
	input wire              ref_clk,
	input wire              sys_rst,
	// User side
	input wire              poll_start,
	input wire [ADDR_W-1:0] poll_addr,
	input wire              poll_ready,
	input wire              poll_done,
	input wire              poll_ok,
	input wire              poll_fail,
	// Flash pins
	input wire [ADDR_W-1:0] flash_addr,
	input wire [7:0]        flash_dq_out,
	input wire              flash_dq_oe,
	input wire              flash_ce_n,
	input wire              flash_oe_n,
	input wire              flash_we_n,
	input wire              ready_busy_n_oe
);
	reg [ADDR_W-1:0] addr_q;
	reg [3:0]        n_rd;
	reg              wrote;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////////////////////////////
	// Per-poll bookkeeping, cleared when a poll is taken
	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			addr_q <= {ADDR_W{1'b0}};
			n_rd   <= 4'h0;
			wrote  <= 1'b0;
		end else if (poll_start && poll_ready) begin
			addr_q <= poll_addr;
			n_rd   <= 4'h0;
			wrote  <= 1'b0;
		end else begin
			if ($fell(flash_oe_n) && n_rd != 4'hf)
				n_rd <= n_rd + 4'h1;
			if ($fell(flash_we_n))
				wrote <= 1'b1;
		end
	end
	////////////////////////////////////////////////////////////////
	AST_RB_RELEASED: assert property (!ready_busy_n_oe)
		else $error("host drives ready_busy_n");
	AST_ONE_STROBE: assert property (flash_oe_n || flash_we_n)
		else $error("read and write strobes together");
	AST_READ_SEL: assert property (!flash_oe_n |-> !flash_ce_n && !flash_dq_oe)
		else $error("read without select or with bus driven");
	AST_READ_HOLD: assert property ($fell(flash_oe_n) |=> $stable(flash_addr) [*2])
		else $error("address moved during read");
	AST_READ_ADDR: assert property (!flash_oe_n |-> flash_addr == addr_q)
		else $error("status read at wrong address");
	AST_TWO_READS: assert property (poll_done |-> n_rd >= 4'h2)
		else $error("verdict after fewer than two reads");
	AST_RESET_CMD: assert property ($fell(flash_we_n) |-> flash_dq_oe && flash_dq_out == 8'hf0)
		else $error("write is not the reset command");
	AST_FAIL_WRITE: assert property (poll_done |-> wrote == poll_fail)
		else $error("reset write does not match failure");
	AST_VERDICT: assert property (poll_done |-> poll_ok != poll_fail)
		else $error("ok and fail not exclusive");
	AST_DONE_PULSE: assert property (poll_done |=> !poll_done)
		else $error("done longer than one cycle");
endmodule // flash_status_poller_props

bind flash_status_poller flash_status_poller_props #(.ADDR_W(ADDR_W)) props (
	.ref_clk(ref_clk), .sys_rst(sys_rst), .poll_start(poll_start), .poll_addr(poll_addr),
	.poll_ready(poll_ready), .poll_done(poll_done), .poll_ok(poll_ok), .poll_fail(poll_fail),
	.flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
	.flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
	.ready_busy_n_oe(ready_busy_n_oe)
);

// >>> tb/flash_status_poller_test.sv
// Self-checking bench for the flash status poller
`timescale 1ns/100ps
module flash_status_poller_test;
	reg         ref_clk      = 1'b0;
	reg         sys_rst      = 1'b1;
	reg         poll_start   = 1'b0;
	reg  [1:0]  poll_mode    = 2'h0;
	reg  [19:0] poll_addr    = 20'h00000;
	reg  [7:0]  poll_data    = 8'h00;
	reg         window_check = 1'b0;
	wire        poll_ready, poll_done, poll_ok, poll_fail;
	wire        window_open, window_valid, suspended;
	wire [7:0]  last_status, dq_out, dev_dq;
	wire [19:0] addr;
	wire        dq_oe, ce_n, oe_n, we_n, rb_out, rb_oe, dev_busy;
	wire [7:0]  dq_in = dq_oe ? dq_out : dev_dq;
	// Pull-up on the shared ready line
	wire        rb_n  = !(dev_busy || (rb_oe && !rb_out));
	integer     n_fail = 0;
	integer     checks_done = 0;
	integer     i;
	reg  [31:0] rnd;

	initial forever #50 ref_clk = ~ref_clk;

	flash_status_poller dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .poll_start(poll_start),
		.poll_mode(poll_mode), .poll_addr(poll_addr), .poll_data(poll_data), .window_check(window_check),
		.poll_ready(poll_ready), .poll_done(poll_done), .poll_ok(poll_ok), .poll_fail(poll_fail),
		.window_open(window_open), .window_valid(window_valid), .suspended(suspended),
		.last_status(last_status), .flash_addr(addr), .flash_dq_in(dq_in), .flash_dq_out(dq_out),
		.flash_dq_oe(dq_oe), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
		.ready_busy_n_in(rb_n), .ready_busy_n_out(rb_out), .ready_busy_n_oe(rb_oe));
	flash_dev_model dev (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .din(dq_out), .dout(dev_dq), .busy(dev_busy));

	////////////////////////////////////////////////////////////////
	task summarize;
		begin
			if (n_fail == 0 && checks_done > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask
	task chk1(input got, input exp);
		begin
			checks_done = checks_done + 1;
			if (got !== exp) begin
				n_fail = n_fail + 1;
				$display("mismatch at %0t: flag %b expected %b", $time, got, exp);
			end
		end
	endtask
	task chk8(input [7:0] got, input [7:0] exp);
		begin
			checks_done = checks_done + 1;
			if (got !== exp) begin
				n_fail = n_fail + 1;
				$display("mismatch at %0t: byte %h expected %h", $time, got, exp);
			end
		end
	endtask
	// Finished program reads the byte, finished erase reads all ones
	function [7:0] exp_byte(input [1:0] o, input [7:0] d);
		exp_byte = (o == 2'h2) ? 8'hff : d;
	endfunction
	task run(input [1:0] m, input [1:0] o, input [7:0] n, input f, input w, input wc);
		integer k;
		begin
			dev.op = o;
			dev.left = n;
			dev.fail = f;
			dev.win = w;
			dev.pdata = exp_byte(o, rnd[7:0]);
			poll_mode = m;
			poll_data = dev.pdata;
			window_check = wc;
			poll_addr = rnd[27:8];
			poll_start = 1'b1;
			@(negedge ref_clk);
			poll_start = 1'b0;
			k = 0;
			while (poll_done !== 1'b1 && k < 3000) begin
				@(negedge ref_clk);
				k = k + 1;
			end
			chk1(poll_done, 1'b1);
			chk1(poll_ok, !f);
			chk1(poll_fail, f);
			chk1(poll_ready, 1'b1);
		end
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		rnd = $urandom(37324);
		repeat (20) @(negedge ref_clk);
		sys_rst = 1'b0;
		@(negedge ref_clk);
		for (i = 0; i < 8; i = i + 1) begin
			rnd = $urandom;
			run({1'b0, i[0]}, 2'h1, {4'h0, rnd[31:28]}, 1'b0, 1'b0, 1'b0);
			chk8(last_status, exp_byte(2'h1, rnd[7:0]));
		end
		run(2'h0, 2'h2, 8'h05, 1'b0, 1'b0, 1'b1);
		chk8(last_status, exp_byte(2'h2, 8'h00));
		chk1(window_valid, 1'b0);
		chk1(suspended, 1'b0);
		run(2'h2, 2'h2, 8'h04, 1'b0, 1'b0, 1'b1);
		chk1(window_valid, 1'b1);
		chk1(window_open, 1'b1);
		run(2'h2, 2'h2, 8'h04, 1'b0, 1'b1, 1'b1);
		chk1(window_open, 1'b0);
		run(2'h0, 2'h1, 8'h03, 1'b1, 1'b0, 1'b0);
		chk1(poll_fail, 1'b1);
		chk1(last_status[5], 1'b1);
		chk1(rb_n, 1'b1);
		run(2'h2, 2'h3, 8'h00, 1'b0, 1'b0, 1'b0);
		chk1(suspended, 1'b1);
		summarize;
	end

	// Thirteen polls of under two hundred cycles each fit well inside this
	initial begin
		#3000000;
		n_fail = n_fail + 1;
		summarize;
	end
endmodule // flash_status_poller_test
